// ---- keying_mixer.sv ----
// Keying mixer: APB registers, source selection, edge alignment, output.
`timescale 1ns/1ps
`include "keying_mixer_map.svh"

module keying_mixer (
  input  wire logic                  clock,          // 10 MHz clock
  input  wire logic                  rstn,           // async reset, low
  input  wire logic                  psel,           // APB select
  input  wire logic                  penable,        // APB access phase
  input  wire logic                  pwrite,         // APB write
  input  wire logic [`KM_AW-1:0]     paddr,          // APB byte address
  input  wire logic [31:0]           pwdata,         // APB write data
  input  wire logic [3:0]            pstrb,          // APB byte strobes
  output logic      [31:0]           prdata,         // APB read data
  output logic                       pready,         // APB ready
  output logic                       pslverr,        // APB error
  input  wire logic [`KM_PINS-1:0]   pinIn,          // source pins
  input  wire logic [`KM_PERIPH-1:0] periphIn,       // peripheral sources
  output logic                       mixedResultPin  // mixed output
);
  import keying_mixer_pkg::*;

  mixer_s st_r;
  mixer_s st_nxt;

  logic [`KM_PINS-1:0] pinS;
  logic                modPin;
  logic                chPin;
  logic                clPin;
  logic                dataRaw;
  logic                hiRaw;
  logic                loRaw;
  logic                dataSel;
  logic                hiCar;
  logic                loCar;
  logic                result;
  logic                holdSw;
  logic                setupPh;
  logic                wrPh;
  logic                hit;
  logic [31:0]         rdVal;

  keying_pin_sync u_sync (
    .clock  (clock),
    .rstn   (rstn),
    .pinIn  (pinIn),
    .pinOut (pinS)
  );

  // Pin selects beyond the implemented pins read as a quiet zero.
  assign modPin = (st_r.modPps < 6'h08) ? pinS[st_r.modPps[2:0]] : 1'b0;
  assign chPin  = (st_r.chPps < 6'h08) ? pinS[st_r.chPps[2:0]] : 1'b0;
  assign clPin  = (st_r.clPps < 6'h08) ? pinS[st_r.clPps[2:0]] : 1'b0;

  keying_source_mux u_data (
    .code    (st_r.msSel),
    .softBit (st_r.softBit),
    .pinBit  (modPin),
    .periph  (periphIn),
    .srcOut  (dataRaw)
  );

  // Carrier code 0 is ground, so the software bit input is tied low.
  keying_source_mux u_hi (
    .code    ({1'b0, st_r.chSel}),
    .softBit (1'b0),
    .pinBit  (chPin),
    .periph  (periphIn),
    .srcOut  (hiRaw)
  );

  keying_source_mux u_lo (
    .code    ({1'b0, st_r.clSel}),
    .softBit (1'b0),
    .pinBit  (clPin),
    .periph  (periphIn),
    .srcOut  (loRaw)
  );

  // Stored selections are untouched by enable; only the gating changes.
  assign dataSel = st_r.en ? dataRaw : st_r.softBit;
  assign hiCar   = st_r.en ? (hiRaw ^ st_r.hi_carrier_invert) : 1'b0;
  assign loCar   = st_r.en ? (loRaw ^ st_r.lo_carrier_invert) : 1'b0;

  // The active carrier tracks the data level; with data high the high
  // carrier passes, with data low the low carrier passes.
  assign result = st_r.activeHi ? hiCar : loCar;

  // A switch waits while the outgoing synced carrier is still high.
  assign holdSw = (dataSel != st_r.activeHi) &&
                  (st_r.activeHi ? (st_r.hi_carrier_edge_align && hiCar)
                                 : (st_r.lo_carrier_edge_align && loCar));

  assign setupPh = psel && !penable;
  assign wrPh    = psel && penable && pwrite && pstrb[0];

  always_comb begin
    rdVal = 32'h0000_0000;
    hit   = 1'b1;
    if (paddr == `KM_CTL0) begin
      rdVal[`KM_EN_BIT]   = st_r.en;
      rdVal[`KM_OUT_BIT]  = st_r.outPin;
      rdVal[`KM_RESULT_INVERT_BIT] = st_r.result_invert;
      rdVal[`KM_SOFT_BIT] = st_r.softBit;
    end else if (paddr == `KM_CTL1) begin
      rdVal[`KM_HI_CARRIER_INVERT_BIT]  = st_r.hi_carrier_invert;
      rdVal[`KM_HI_CARRIER_EDGE_ALIGN_BIT] = st_r.hi_carrier_edge_align;
      rdVal[`KM_LO_CARRIER_INVERT_BIT]  = st_r.lo_carrier_invert;
      rdVal[`KM_LO_CARRIER_EDGE_ALIGN_BIT] = st_r.lo_carrier_edge_align;
    end else if (paddr == `KM_SRC) begin
      rdVal[`KM_MS_W-1:0] = st_r.msSel;
    end else if (paddr == `KM_HIGH_CARRIER_SIGNAL) begin
      rdVal[`KM_CAR_W-1:0] = st_r.chSel;
    end else if (paddr == `KM_LOW_CARRIER_SIGNAL) begin
      rdVal[`KM_CAR_W-1:0] = st_r.clSel;
    end else if (paddr == `KM_MODPPS) begin
      rdVal[`KM_PPS_W-1:0] = st_r.modPps;
    end else if (paddr == `KM_CHPPS) begin
      rdVal[`KM_PPS_W-1:0] = st_r.chPps;
    end else if (paddr == `KM_CLPPS) begin
      rdVal[`KM_PPS_W-1:0] = st_r.clPps;
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    // Nothing here depends on a low-power state, so sleep changes nothing.
    if (!holdSw) begin
      st_nxt.activeHi = dataSel;
    end
    // The pin value is produced whether or not any pin carries it.
    st_nxt.outPin = result ^ st_r.result_invert;
    if (setupPh) begin
      st_nxt.rdData = pwrite ? 32'h0000_0000 : rdVal;
      st_nxt.slvErr = !hit;
    end
    if (wrPh && hit) begin
      if (paddr == `KM_CTL0) begin
        st_nxt.en      = pwdata[`KM_EN_BIT];
        st_nxt.result_invert    = pwdata[`KM_RESULT_INVERT_BIT];
        st_nxt.softBit = pwdata[`KM_SOFT_BIT];
      end else if (paddr == `KM_CTL1) begin
        st_nxt.hi_carrier_invert  = pwdata[`KM_HI_CARRIER_INVERT_BIT];
        st_nxt.hi_carrier_edge_align = pwdata[`KM_HI_CARRIER_EDGE_ALIGN_BIT];
        st_nxt.lo_carrier_invert  = pwdata[`KM_LO_CARRIER_INVERT_BIT];
        st_nxt.lo_carrier_edge_align = pwdata[`KM_LO_CARRIER_EDGE_ALIGN_BIT];
      end else if (paddr == `KM_SRC) begin
        st_nxt.msSel = pwdata[`KM_MS_W-1:0];
      end else if (paddr == `KM_HIGH_CARRIER_SIGNAL) begin
        st_nxt.chSel = pwdata[`KM_CAR_W-1:0];
      end else if (paddr == `KM_LOW_CARRIER_SIGNAL) begin
        st_nxt.clSel = pwdata[`KM_CAR_W-1:0];
      end else if (paddr == `KM_MODPPS) begin
        st_nxt.modPps = pwdata[`KM_PPS_W-1:0];
      end else if (paddr == `KM_CHPPS) begin
        st_nxt.chPps = pwdata[`KM_PPS_W-1:0];
      end else begin
        st_nxt.clPps = pwdata[`KM_PPS_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= MIXER_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Reads are captured in the setup phase, so the slave never waits.
  assign pready         = 1'b1;
  assign prdata         = st_r.rdData;
  assign pslverr        = st_r.slvErr;
  assign mixedResultPin = st_r.outPin;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence wrTo(logic [`KM_AW-1:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence

  sequence rdFrom(logic [`KM_AW-1:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  hi_mix_a: assert property (
    st_r.en && st_r.activeHi |=>
      mixedResultPin == $past(hiCar ^ st_r.result_invert))
    else $error("high carrier not mixed while data high");

  lo_mix_a: assert property (
    st_r.en && !st_r.activeHi |=>
      mixedResultPin == $past(loCar ^ st_r.result_invert))
    else $error("low carrier not mixed while data low");

  disabled_idle_a: assert property (
    !st_r.en |=> mixedResultPin == $past(st_r.result_invert))
    else $error("disabled output not at idle level");

  soft_data_a: assert property (
    !st_r.en |=> st_r.activeHi == $past(st_r.softBit))
    else $error("disabled data not taken from software bit");

  sync_hold_a: assert property (
    holdSw |=> $stable(st_r.activeHi))
    else $error("carrier switched before pulse ended");

  hi_nosync_a: assert property (
    st_r.en && !st_r.hi_carrier_edge_align && st_r.activeHi && !dataSel
      |=> !st_r.activeHi)
    else $error("unsynced high carrier did not switch");

  lo_nosync_a: assert property (
    st_r.en && !st_r.lo_carrier_edge_align && !st_r.activeHi && dataSel
      |=> st_r.activeHi)
    else $error("unsynced low carrier did not switch");

  hi_invert_a: assert property (
    st_r.en && st_r.chSel == `KM_CAR_ZERO |-> hiCar == st_r.hi_carrier_invert)
    else $error("high carrier polarity not applied");

  rsvd_zero_a: assert property (
    st_r.en && st_r.clSel > `KM_CAR_RSVD |-> loCar == st_r.lo_carrier_invert)
    else $error("reserved low carrier code not zero");

  src_write_a: assert property (
    wrTo(`KM_SRC) |=> st_r.msSel == $past(pwdata[`KM_MS_W-1:0]))
    else $error("data source field not written");

  keep_sel_a: assert property (
    $fell(st_r.en) |-> $stable(st_r.msSel) && $stable(st_r.chSel)
      && $stable(st_r.clSel))
    else $error("selections changed when disabled");

  status_a: assert property (
    rdFrom(`KM_CTL0) |=> prdata[`KM_OUT_BIT] == $past(st_r.outPin))
    else $error("status bit does not show output");
endmodule

// ---- keying_mixer_map.svh ----
// Address map, field positions and source codes of the keying mixer.
`ifndef KEYING_MIXER_MAP_SVH
`define KEYING_MIXER_MAP_SVH

`define KM_AW         8
`define KM_PINS       8
`define KM_PERIPH     8

`define KM_CTL0       8'h00
`define KM_CTL1       8'h04
`define KM_SRC        8'h08
`define KM_HIGH_CARRIER_SIGNAL       8'h0C
`define KM_LOW_CARRIER_SIGNAL       8'h10
`define KM_MODPPS     8'h14
`define KM_CHPPS      8'h18
`define KM_CLPPS      8'h1C

`define KM_EN_BIT     7
`define KM_OUT_BIT    5
`define KM_RESULT_INVERT_BIT   4
`define KM_SOFT_BIT   0
`define KM_HI_CARRIER_INVERT_BIT  5
`define KM_HI_CARRIER_EDGE_ALIGN_BIT 4
`define KM_LO_CARRIER_INVERT_BIT  1
`define KM_LO_CARRIER_EDGE_ALIGN_BIT 0

`define KM_MS_W       5
`define KM_CAR_W      4
`define KM_PPS_W      6

`define KM_CODE_SW    5'h00
`define KM_CODE_PIN   5'h01
`define KM_CODE_P0    5'h02
`define KM_CODE_LAST  5'h09
`define KM_CAR_ZERO   4'h0
`define KM_CAR_RSVD   4'h9

`endif

// ---- keying_mixer_pkg.sv ----
// Types shared by the keying mixer modules.
`include "keying_mixer_map.svh"

package keying_mixer_pkg;

  typedef struct packed {
    logic [`KM_PINS-1:0] s1;
    logic [`KM_PINS-1:0] s2;
    logic [`KM_PINS-1:0] s3;
    logic [`KM_PINS-1:0] q;
  } pin_sync_s;

  typedef struct packed {
    logic                 en;
    logic                 result_invert;
    logic                 softBit;
    logic                 hi_carrier_invert;
    logic                 hi_carrier_edge_align;
    logic                 lo_carrier_invert;
    logic                 lo_carrier_edge_align;
    logic [`KM_MS_W-1:0]  msSel;
    logic [`KM_CAR_W-1:0] chSel;
    logic [`KM_CAR_W-1:0] clSel;
    logic [`KM_PPS_W-1:0] modPps;
    logic [`KM_PPS_W-1:0] chPps;
    logic [`KM_PPS_W-1:0] clPps;
    logic                 activeHi;
    logic                 outPin;
    logic [31:0]          rdData;
    logic                 slvErr;
  } mixer_s;

  localparam mixer_s MIXER_RST = '0;
  localparam pin_sync_s SYNC_RST = '0;

endpackage

// ---- keying_pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/1ps
`include "keying_mixer_map.svh"

module keying_pin_sync (
  input  wire logic                clock,  // system clock
  input  wire logic                rstn,   // async reset, active low
  input  wire logic [`KM_PINS-1:0] pinIn,  // raw pin levels
  output logic      [`KM_PINS-1:0] pinOut  // filtered pin levels
);
  import keying_mixer_pkg::*;

  pin_sync_s st_r;
  pin_sync_s st_nxt;
  logic [`KM_PINS-1:0] agree;

  // The first stage feeds only the second; filtering looks at 2 and 3.
  assign agree = ~(st_r.s2 ^ st_r.s3);

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q  = (st_r.s2 & agree) | (st_r.q & ~agree);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= SYNC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pinOut = st_r.q;
endmodule

// ---- keying_source_mux.sv ----
// Source selector for the data stream and the two carriers.
`timescale 1ns/1ps
`include "keying_mixer_map.svh"

module keying_source_mux (
  input  wire logic [`KM_MS_W-1:0]   code,    // source selection code
  input  wire logic                  softBit, // software keying bit
  input  wire logic                  pinBit,  // pin chosen by pin select
  input  wire logic [`KM_PERIPH-1:0] periph,  // internal peripheral outputs
  output logic                       srcOut   // selected source level
);
  import keying_mixer_pkg::*;

  always_comb begin
    if (code == `KM_CODE_SW) begin
      srcOut = softBit;
    end else if (code == `KM_CODE_PIN) begin
      srcOut = pinBit;
    end else if (code <= `KM_CODE_LAST) begin
      srcOut = periph[3'(code - `KM_CODE_P0)];
    end else begin
      srcOut = 1'b0;
    end
  end
endmodule

// ---- keying_source_model.sv ----
// Behavioural model of the peripherals and pins that feed the mixer.
`timescale 1ns/1ps
`include "keying_mixer_map.svh"

module keying_source_model (
  input  wire logic                  clock,     // system clock
  input  wire logic [`KM_PERIPH-1:0] periphSet, // levels to present
  input  wire logic [`KM_PINS-1:0]   pinSet,    // pin levels to present
  output logic      [`KM_PERIPH-1:0] periphIn,  // peripheral outputs
  output logic      [`KM_PINS-1:0]   pinIn      // pin levels
);
  initial begin
    periphIn = 8'h00;
    pinIn    = 8'h00;
  end
  // Sources move just after the edge, as same-clock peripherals do.
  always @(posedge clock) begin
    periphIn <= periphSet;
    pinIn    <= pinSet;
  end
endmodule

// ---- keying_mixer_tb_top.sv ----
// Self-checking bench for the keying mixer.
`timescale 1ns/1ps
`include "keying_mixer_map.svh"

module keying_mixer_tb_top;
  logic        clock;          // system clock
  logic        rstn;           // reset, active low
  logic        psel;           // APB select
  logic        penable;        // APB access phase
  logic        pwrite;         // APB direction
  logic [7:0]  paddr;          // APB address
  logic [31:0] pwdata;         // APB write data
  logic [31:0] prdata;         // APB read data
  logic        pready;         // APB ready
  logic        pslverr;        // APB error
  logic [7:0]  periphSet;      // requested peripheral levels
  logic [7:0]  pinSet;         // requested pin levels
  logic [7:0]  periphIn;       // peripheral levels at the mixer
  logic [7:0]  pinIn;          // pin levels at the mixer
  logic        mixedResultPin; // mixer output
  int          fails;
  int          comparisons;
  int          cycles;

  keying_mixer keying_mixer_inst (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinIn(pinIn), .periphIn(periphIn), .mixedResultPin(mixedResultPin));
  keying_source_model keying_source_model_inst (.clock(clock),
    .periphSet(periphSet), .pinSet(pinSet), .periphIn(periphIn),
    .pinIn(pinIn));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // A hang anywhere ends the run here with a counted mismatch.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, (a > `KM_CLPPS)});
  endtask

  // Waits past the source and output registers, then looks at the pin.
  task automatic outChk(input int n, input logic exp);
    repeat (n) @(posedge clock);
    #1;
    chk({31'h0, mixedResultPin}, {31'h0, exp});
  endtask

  task automatic test_reset();
    for (int a = 0; a <= 8'h20; a += 4) rdChk(a[7:0], 32'h0);
    outChk(1, 1'b0);
  endtask

  task automatic test_fields();
    wr(`KM_SRC, 32'hFF);
    rdChk(`KM_SRC, 32'h1F);
    wr(`KM_HIGH_CARRIER_SIGNAL, 32'hFF);
    rdChk(`KM_HIGH_CARRIER_SIGNAL, 32'h0F);
    wr(`KM_LOW_CARRIER_SIGNAL, 32'hFF);
    rdChk(`KM_LOW_CARRIER_SIGNAL, 32'h0F);
    wr(`KM_CTL0, 32'h6E);
    rdChk(`KM_CTL0, 32'h00);
  endtask

  task automatic test_disabled();
    periphSet <= 8'hFF;
    wr(`KM_SRC, 32'h02);
    wr(`KM_HIGH_CARRIER_SIGNAL, 32'h02);
    wr(`KM_LOW_CARRIER_SIGNAL, 32'h02);
    wr(`KM_CTL0, 32'h11);
    outChk(3, 1'b1);
    wr(`KM_CTL0, 32'h01);
    outChk(3, 1'b0);
    rdChk(`KM_SRC, 32'h02);
  endtask

  task automatic test_truth();
    logic [4:0] i;
    logic       exp;
    wr(`KM_SRC, 32'h00);
    wr(`KM_HIGH_CARRIER_SIGNAL, 32'h02);
    wr(`KM_LOW_CARRIER_SIGNAL, 32'h03);
    for (int k = 0; k < 32; k++) begin
      i = k[4:0];
      exp = (i[0] ? i[1] ^ i[3] : i[2] ^ i[3]) ^ i[4];
      periphSet <= {6'h00, i[2], i[1]};
      wr(`KM_CTL1, i[3] ? 32'h22 : 32'h00);
      wr(`KM_CTL0, {24'h0, 3'b100, i[4], 3'b000, i[0]});
      outChk(3, exp);
      rdChk(`KM_CTL0, {24'h0, 2'b10, exp, i[4], 3'b000, i[0]});
    end
  endtask

  task automatic test_sources();
    // The last truth pass leaves the result inverted; start plain.
    wr(`KM_CTL0, 32'h80);
    wr(`KM_CTL1, 32'h00);
    periphSet <= 8'h80;
    wr(`KM_SRC, 32'h09);
    wr(`KM_LOW_CARRIER_SIGNAL, 32'h0F);
    wr(`KM_HIGH_CARRIER_SIGNAL, 32'h0A);
    outChk(3, 1'b0);
    wr(`KM_HIGH_CARRIER_SIGNAL, 32'h09);
    outChk(3, 1'b1);
    pinSet <= 8'h08;
    wr(`KM_HIGH_CARRIER_SIGNAL, 32'h01);
    wr(`KM_CHPPS, 32'h03);
    outChk(8, 1'b1);
    wr(`KM_CHPPS, 32'h04);
    outChk(8, 1'b0);
    wr(`KM_CHPPS, 32'h03);
    wr(`KM_CTL0, 32'h00);
    outChk(3, 1'b0);
    wr(`KM_CTL0, 32'h80);
    outChk(8, 1'b1);
    wr(`KM_HIGH_CARRIER_SIGNAL, 32'h00);
    outChk(3, 1'b0);
  endtask

  task automatic syncCase(input logic [31:0] ctl1, input logic [7:0] lvl,
                          input logic start, input logic exp);
    periphSet <= lvl;
    wr(`KM_CTL1, ctl1);
    wr(`KM_CTL0, {24'h0, 7'b1000000, start});
    outChk(3, 1'b1);
    wr(`KM_CTL0, {24'h0, 7'b1000000, ~start});
    outChk(3, exp);
  endtask

  task automatic test_sync();
    wr(`KM_SRC, 32'h00);
    wr(`KM_HIGH_CARRIER_SIGNAL, 32'h02);
    wr(`KM_LOW_CARRIER_SIGNAL, 32'h03);
    syncCase(32'h10, 8'h01, 1'b1, 1'b1);
    periphSet <= 8'h00;
    outChk(3, 1'b0);
    periphSet <= 8'h02;
    outChk(3, 1'b1);
    syncCase(32'h00, 8'h01, 1'b1, 1'b0);
    syncCase(32'h10, 8'h02, 1'b0, 1'b0);
    syncCase(32'h01, 8'h02, 1'b0, 1'b1);
  endtask

  initial begin
    fails = 0;
    comparisons = 0;
    cycles = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    periphSet = 8'h00;
    pinSet = 8'h00;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    test_reset();
    test_fields();
    test_disabled();
    test_truth();
    test_sources();
    test_sync();
    tally_and_finish();
  end
endmodule
